// ===== rtl/olm_defines.svh
/*
  Offsets, field positions, widths and reset values of the OAM loopback,
  test and loss-measurement block. Assumes inclusion by bare name.
*/
`ifndef OLM_DEFINES_SVH
`define OLM_DEFINES_SVH

`define OLM_CNT_W 32
`define OLM_TXN_W 32
`define OLM_SEQ_W 5
`define OLM_SVC_W 10
`define OLM_PORT_W 4
`define OLM_MAC_W 48
`define OLM_CLASSES 8
`define OLM_CNT_SETS 6
`define OLM_TST_FWD_BIT 6
`define OLM_FOLD_CLASS 3'h7
`define OLM_UP_TXN_W 16
`define OLM_REW_SEQ_LSB 27
`define OLM_SEQ_LMM_LSB 26
`define OLM_SEQ_LMR_LSB 21
`define OLM_SEQ_CCM_LSB 16
`define OLM_LB_SEQ_LSB 0
`define OLM_SET_MEP_RX 3'h0
`define OLM_SET_MEP_TX 3'h1
`define OLM_SET_PATH_RX 3'h2
`define OLM_SET_PATH_TX 3'h3
`define OLM_SET_PORT_RX 3'h4
`define OLM_SET_PORT_TX 3'h5
`define OLM_CNT_RST 32'h0
`define OLM_TXN_RST 32'h0
`define OLM_SEQ_RST 5'h0
`define OLM_RSEQ_RST 32'h0
`define OLM_SVC_RST 10'h0

`endif

// ===== rtl/olm_pkg.sv
/*
  Types of the OAM loopback, test and loss-measurement block.
  Assumes olm_defines.svh is on the include path.
*/
`include "olm_defines.svh"

package olm_pkg;

  typedef enum logic [2:0] {
    OLM_KIND_DATA = 3'b000,
    OLM_KIND_LBM = 3'b001,
    OLM_KIND_LBR = 3'b010,
    OLM_KIND_TST = 3'b011,
    OLM_KIND_LMM = 3'b100,
    OLM_KIND_LMR = 3'b101,
    OLM_KIND_CCM_LM = 3'b110,
    OLM_KIND_OTHER = 3'b111
  } olm_kind_type;

  typedef enum logic [1:0] {
    OLM_MEL_SAME = 2'b00,
    OLM_MEL_HIGHER = 2'b01,
    OLM_MEL_LOWER = 2'b10
  } olm_mel_type;

  typedef struct packed {
    logic tx_dir;
    olm_kind_type kind;
    olm_mel_type mel_rel;
    logic [2:0] pcp;
    logic yellow;
    logic prot;
    logic [`OLM_PORT_W-1:0] port;
    logic [`OLM_SVC_W-1:0] service_index;
    logic [`OLM_MAC_W-1:0] dmac;
    logic [`OLM_MAC_W-1:0] smac;
    logic [`OLM_TXN_W-1:0] txn;
    logic [`OLM_CNT_W-1:0] fc_tx;
    logic [`OLM_CNT_W-1:0] fc_rx;
    logic copy_host;
    logic discard;
    logic [31:0] extraction_rewrite_value;
  } olm_frame_type;

endpackage

// ===== rtl/olm_stream_if.sv
/*
  Frame descriptor stream between the processing logic and the buffer.
  Assumes one clock; a word moves when valid and ready are both high.
*/
interface olm_stream_if;
  import olm_pkg::*;
  logic valid;
  logic ready;
  olm_frame_type data;
  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

// ===== rtl/olm_buf.sv
/*
  Two-entry buffer (output word plus skid word) on the descriptor path.
  Assumes a synchronous sink; ready and all outputs come from flops.
*/
module olm_buf (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  olm_stream_if.consumer in_if,
  output logic out_valid_out,
  output olm_pkg::olm_frame_type out_data_out,
  input wire logic out_ready_in
);
  import olm_pkg::*;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic skid_empty_reg;
  logic skid_valid_reg;
  olm_frame_type skid_reg;
  logic take;
  logic drain;

  assign take = in_if.valid & skid_empty_reg;
  assign drain = ~out_valid_out | out_ready_in;
  assign in_if.ready = skid_empty_reg;

  // skid entry keeps a word taken while the sink stalls, so none is lost
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
      skid_valid_reg <= 1'b0;
      skid_empty_reg <= 1'b1;
      skid_reg <= '0;
    end else if (drain) begin
      out_valid_out <= skid_valid_reg | take;
      out_data_out <= skid_valid_reg ? skid_reg : in_if.data;
      skid_valid_reg <= 1'b0;
      skid_empty_reg <= 1'b1;
    end else if (take) begin
      skid_valid_reg <= 1'b1;
      skid_empty_reg <= 1'b0;
      skid_reg <= in_if.data;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  out_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out))
    else $error("buffered word changed while stalled");
endmodule

// ===== rtl/olm_top.sv
/*
  OAM endpoint engine: loopback, test signal, loss counters and LM
  sequence numbering on a frame descriptor stream.
  Assumes descriptors synchronous to clk_sys_in and static configuration.
*/
// Function
// - down loopback: same port, loopback index; protected active uses protect port/index
// - initiator checks reply transaction id and counts every reply
// - up in-service: copy requests to host when enabled; host builds reply
// - up loopback mode: engine swaps addresses and sets reply opcode itself
// - up endpoint compares and stores only low 16 transaction id bits
// - test frames share loopback configuration and counters
// - test handling only with forward mask bit 6, else unknown type
// - transmitted test frames get sequence number then it increments, only with update enable and both request count enables
// - received test frames checked, counted, optionally copied to host
// - per class transmit and receive in-profile data counters by pcp
// - same-level oam excluded from counters unless enabled per type
// - higher-level oam counted as data; lower-level discarded, uncounted
// - linked path counters and port counters also updated
// - fold mask sends a class to class 7; yellow counting selectable
// - 5-bit lm sequence increments and is saved per sample
// - extracted lm frame carries sequence in rewrite bits 31:27
// - latest sequence sent to host kept in loopback index bits 4:0
// - lmm, lmr, ccm-lm sequence stored at bits 30:26, 25:21, 20:16
// - initiator writes transmit counter sample into outgoing lmm
// - remote: rx sample into lmm, swap, lmr; tx sample into lmr
// - expected reply id is configured plus one, then auto increments
// - with update enable, outgoing id written into request then increments
`include "olm_defines.svh"

module olm_top (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic frm_valid_in,
  input olm_pkg::olm_frame_type frm_in,
  output logic frm_ready_out,
  output logic frm_valid_out,
  output olm_pkg::olm_frame_type frm_out,
  input wire logic frm_ready_in,
  input wire logic mep_up_in,
  input wire logic up_endpoint_loop_select_in,
  input wire logic request_hw_handling_enable_in,
  input wire logic request_copy_to_host_enable_in,
  input wire logic reply_copy_to_host_enable_in,
  input wire logic request_txn_id_update_enable_in,
  input wire logic request_oam_count_enable_in,
  input wire logic request_data_count_enable_in,
  input wire logic [7:0] generic_forward_mask_in,
  input wire logic [7:0] oam_in_data_count_ctrl_in,
  input wire logic [7:0] class_counter_fold_mask_in,
  input wire logic yellow_frame_count_enable_in,
  input wire logic path_link_in,
  input wire logic protect_active_in,
  input wire logic [`OLM_PORT_W-1:0] protect_loopback_port_in,
  input wire logic [`OLM_SVC_W-1:0] protect_service_index_in,
  input wire logic [`OLM_MAC_W-1:0] mep_mac_in,
  input wire logic cfg_load_in,
  input wire logic [`OLM_SVC_W-1:0] loopback_service_index_in,
  input wire logic [`OLM_TXN_W-1:0] outgoing_request_txn_id_in,
  input wire logic [`OLM_TXN_W-1:0] expected_reply_txn_id_in,
  input wire logic [2:0] cnt_set_in,
  input wire logic [2:0] cnt_class_in,
  output logic [`OLM_CNT_W-1:0] cnt_value_out,
  output logic [`OLM_CNT_W-1:0] reply_receive_counter_out,
  output logic reply_txn_error_out,
  output logic [`OLM_TXN_W-1:0] outgoing_request_txn_id_out,
  output logic [`OLM_TXN_W-1:0] expected_reply_txn_id_out,
  output logic [`OLM_SVC_W-1:0] loopback_service_index_out,
  output logic [31:0] received_sequence_store_out,
  output logic [`OLM_SEQ_W-1:0] lm_rx_seq_out
);
  import olm_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [`OLM_CNT_W-1:0] cnt_reg [0:`OLM_CNT_SETS-1][0:`OLM_CLASSES-1];
  logic [`OLM_SEQ_W-1:0] seq_next;
  logic [`OLM_TXN_W-1:0] exp_plus1;
  olm_frame_type f;
  olm_frame_type proc_frame;
  olm_kind_type kind_eff;
  logic acc;
  logic is_rx;
  logic same_lvl;
  logic lower_lvl;
  logic higher_lvl;
  logic counted;
  logic [2:0] cls;
  logic tst_on;
  logic lb_hw;
  logic up_loop;
  logic rx_req;
  logic loop_req;
  logic copy_req;
  logic rx_reply;
  logic tx_req;
  logic txn_match;
  logic lmm_loop;
  logic lmm_svc;
  logic lmr_rx;
  logic ccm_rx;
  logic lm_event;
  logic tx_lmm;
  logic tx_lmr;
  logic [`OLM_CNT_W-1:0] rx_sample;
  logic [`OLM_CNT_W-1:0] tx_sample;
  logic [`OLM_SVC_W-1:0] loop_svc;
  logic [`OLM_PORT_W-1:0] loop_port;

  olm_stream_if buf_if ();

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign f = frm_in;
  assign acc = frm_valid_in & buf_if.ready;
  assign is_rx = ~f.tx_dir;
  assign same_lvl = f.mel_rel == OLM_MEL_SAME;
  assign lower_lvl = f.mel_rel == OLM_MEL_LOWER;
  assign higher_lvl = f.mel_rel == OLM_MEL_HIGHER;
  assign tst_on = generic_forward_mask_in[`OLM_TST_FWD_BIT];
  // test frames fall back to unknown type when not enabled
  assign kind_eff = (f.kind == OLM_KIND_TST && !tst_on) ? OLM_KIND_OTHER : f.kind;
  assign lb_hw = request_hw_handling_enable_in;
  assign up_loop = mep_up_in & up_endpoint_loop_select_in;

  // loopback requests
  assign rx_req = acc & same_lvl & is_rx & lb_hw & (kind_eff == OLM_KIND_LBM);
  assign loop_req = rx_req & (~mep_up_in | up_loop);
  assign copy_req = rx_req & mep_up_in & ~up_endpoint_loop_select_in
                  & request_copy_to_host_enable_in;

  // replies and test frames share the reply check and counter
  assign rx_reply = acc & same_lvl & is_rx & lb_hw
                  & (kind_eff == OLM_KIND_LBR || kind_eff == OLM_KIND_TST);
  assign exp_plus1 = expected_reply_txn_id_out + `OLM_TXN_W'(1);
  assign txn_match = mep_up_in
    ? (f.txn[`OLM_UP_TXN_W-1:0] == exp_plus1[`OLM_UP_TXN_W-1:0])
    : (f.txn == exp_plus1);

  // outgoing requests and test frames take the configured id
  assign tx_req = acc & same_lvl & f.tx_dir & lb_hw & request_txn_id_update_enable_in
    & ((kind_eff == OLM_KIND_LBM)
    | ((kind_eff == OLM_KIND_TST) & request_oam_count_enable_in
    & request_data_count_enable_in));

  // loss measurement frames
  assign lmm_loop = acc & same_lvl & is_rx & (f.kind == OLM_KIND_LMM)
                  & (~mep_up_in | up_loop);
  assign lmm_svc = acc & same_lvl & is_rx & (f.kind == OLM_KIND_LMM)
                 & mep_up_in & ~up_endpoint_loop_select_in;
  assign lmr_rx = acc & same_lvl & is_rx & (f.kind == OLM_KIND_LMR);
  assign ccm_rx = acc & same_lvl & is_rx & (f.kind == OLM_KIND_CCM_LM);
  assign lm_event = lmm_svc | lmr_rx | ccm_rx;
  assign seq_next = lm_rx_seq_out + `OLM_SEQ_W'(1);
  assign tx_lmm = acc & same_lvl & f.tx_dir & (f.kind == OLM_KIND_LMM);
  assign tx_lmr = acc & same_lvl & f.tx_dir & (f.kind == OLM_KIND_LMR);

  // counting: data, higher level oam, or same level oam enabled per type
  assign counted = ~lower_lvl
    & ((f.kind == OLM_KIND_DATA) | higher_lvl
    | (same_lvl & oam_in_data_count_ctrl_in[f.kind]))
    & (~f.yellow | yellow_frame_count_enable_in);
  assign cls = class_counter_fold_mask_in[f.pcp] ? `OLM_FOLD_CLASS : f.pcp;
  assign rx_sample = cnt_reg[`OLM_SET_MEP_RX][cls];
  assign tx_sample = cnt_reg[`OLM_SET_MEP_TX][cls];

  assign loop_svc = (f.prot & protect_active_in)
    ? protect_service_index_in : loopback_service_index_out;
  assign loop_port = (f.prot & protect_active_in)
    ? protect_loopback_port_in : f.port;

  // ----------------------------------------
  // frame rewrite
  // ----------------------------------------
  always_comb begin
    proc_frame = f;
    proc_frame.kind = kind_eff;
    proc_frame.discard = lower_lvl;
    if (loop_req | lmm_loop) begin
      proc_frame.kind = loop_req ? OLM_KIND_LBR : OLM_KIND_LMR;
      proc_frame.tx_dir = 1'b1;
      proc_frame.dmac = f.smac;
      proc_frame.smac = mep_mac_in;
      if (!mep_up_in) begin
        proc_frame.port = loop_port;
        proc_frame.service_index = loop_svc;
      end
    end
    if (lmm_loop | lmm_svc) begin
      proc_frame.fc_rx = rx_sample;
    end
    if (tx_lmm | tx_lmr) begin
      proc_frame.fc_tx = tx_sample;
    end
    if (tx_req) begin
      proc_frame.txn = outgoing_request_txn_id_out;
    end
    if (copy_req | (rx_reply & reply_copy_to_host_enable_in)) begin
      proc_frame.copy_host = 1'b1;
    end
    if (lmm_svc | lmr_rx) begin
      proc_frame.copy_host = 1'b1;
      proc_frame.extraction_rewrite_value[`OLM_REW_SEQ_LSB +: `OLM_SEQ_W] = seq_next;
    end
  end

  assign buf_if.valid = frm_valid_in;
  assign buf_if.data = proc_frame;
  assign frm_ready_out = buf_if.ready;

  olm_buf u_buf (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .in_if(buf_if),
    .out_valid_out(frm_valid_out),
    .out_data_out(frm_out),
    .out_ready_in(frm_ready_in)
  );

  // ----------------------------------------
  // loss counters
  // ----------------------------------------
  // set order: mep rx, mep tx, path rx, path tx, port rx, port tx
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int s = 0; s < `OLM_CNT_SETS; s++) begin
        for (int c = 0; c < `OLM_CLASSES; c++) begin
          cnt_reg[s][c] <= `OLM_CNT_RST;
        end
      end
    end else if (acc & counted) begin
      cnt_reg[{2'b00, f.tx_dir}][cls] <= cnt_reg[{2'b00, f.tx_dir}][cls] + `OLM_CNT_W'(1);
      if (path_link_in) begin
        cnt_reg[{2'b01, f.tx_dir}][cls] <= cnt_reg[{2'b01, f.tx_dir}][cls]
                                          + `OLM_CNT_W'(1);
      end
      // port counters run per priority, never folded
      cnt_reg[{2'b10, f.tx_dir}][f.pcp] <= cnt_reg[{2'b10, f.tx_dir}][f.pcp]
                                          + `OLM_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_value_out <= `OLM_CNT_RST;
    end else begin
      cnt_value_out <= (cnt_set_in < `OLM_CNT_SETS) ? cnt_reg[cnt_set_in][cnt_class_in]
                                                   : `OLM_CNT_RST;
    end
  end

  // ----------------------------------------
  // transaction ids and reply count
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      outgoing_request_txn_id_out <= `OLM_TXN_RST;
      expected_reply_txn_id_out <= `OLM_TXN_RST;
      reply_receive_counter_out <= `OLM_CNT_RST;
      reply_txn_error_out <= 1'b0;
    end else begin
      reply_txn_error_out <= rx_reply & ~txn_match;
      if (cfg_load_in) begin
        outgoing_request_txn_id_out <= outgoing_request_txn_id_in;
        expected_reply_txn_id_out <= expected_reply_txn_id_in;
      end else begin
        if (tx_req) begin
          outgoing_request_txn_id_out <= outgoing_request_txn_id_out + `OLM_TXN_W'(1);
        end
        if (rx_reply) begin
          // up endpoint keeps only the low half of the id
          expected_reply_txn_id_out <= mep_up_in
            ? {{(`OLM_TXN_W-`OLM_UP_TXN_W){1'b0}}, exp_plus1[`OLM_UP_TXN_W-1:0]}
            : exp_plus1;
        end
      end
      if (rx_reply) begin
        reply_receive_counter_out <= reply_receive_counter_out + `OLM_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // lm sequence number
  // ----------------------------------------
  // the low index bits double as the sequence store, so a reload of the
  // loopback index also overwrites the last sequence value seen by host
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lm_rx_seq_out <= `OLM_SEQ_RST;
      received_sequence_store_out <= `OLM_RSEQ_RST;
      loopback_service_index_out <= `OLM_SVC_RST;
    end else begin
      if (cfg_load_in) begin
        loopback_service_index_out <= loopback_service_index_in;
      end else if (lm_event) begin
        loopback_service_index_out[`OLM_LB_SEQ_LSB +: `OLM_SEQ_W] <= seq_next;
      end
      if (lm_event) begin
        lm_rx_seq_out <= seq_next;
      end
      if (lmm_svc) begin
        received_sequence_store_out[`OLM_SEQ_LMM_LSB +: `OLM_SEQ_W] <= seq_next;
      end
      if (lmr_rx) begin
        received_sequence_store_out[`OLM_SEQ_LMR_LSB +: `OLM_SEQ_W] <= seq_next;
      end
      if (ccm_rx) begin
        received_sequence_store_out[`OLM_SEQ_CCM_LSB +: `OLM_SEQ_W] <= seq_next;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  seq_step_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    lm_event |=> lm_rx_seq_out == $past(lm_rx_seq_out) + 5'h1)
    else $error("lm sequence did not step by one");

  seq_index_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    lm_event && !cfg_load_in |=> loopback_service_index_out[4:0] == lm_rx_seq_out)
    else $error("loopback index low bits lost the sequence");

  lmr_store_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    lmr_rx |=> received_sequence_store_out[25:21] == lm_rx_seq_out)
    else $error("lmr sequence not stored");

  reply_count_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    rx_reply |=> reply_receive_counter_out == $past(reply_receive_counter_out) + 32'h1)
    else $error("reply not counted");

  tst_gate_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    acc && f.kind == OLM_KIND_TST && !tst_on && f.tx_dir == 1'b0
    |=> $stable(reply_receive_counter_out))
    else $error("disabled test frame was counted");

  txn_out_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    tx_req && !cfg_load_in |-> proc_frame.txn == outgoing_request_txn_id_out
    ##1 outgoing_request_txn_id_out == $past(proc_frame.txn) + 32'h1)
    else $error("outgoing id not used then stepped");

  expect_step_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    rx_reply && !cfg_load_in && !mep_up_in
    |=> expected_reply_txn_id_out == $past(expected_reply_txn_id_out) + 32'h1)
    else $error("expected id did not step");

  low_level_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    acc && lower_lvl ##1 $stable(cnt_set_in) && $stable(cnt_class_in)
    |=> $stable(cnt_value_out))
    else $error("lower level frame reached the counter");

  loop_svc_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    loop_req && !mep_up_in && !(f.prot && protect_active_in)
    |-> proc_frame.service_index == loopback_service_index_out
    && proc_frame.port == f.port && proc_frame.kind == OLM_KIND_LBR)
    else $error("looped request not re-indexed");
endmodule

// ===== sim/olm_peer.sv
/*
  far-side sink of the descriptor stream: takes words into a queue.
  assumes hold and slow are steered by the bench at falling edges.
*/
module olm_peer (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic valid_in,
  input olm_pkg::olm_frame_type data_in,
  input wire logic hold_in,
  input wire logic slow_in,
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import olm_pkg::*;
  olm_frame_type q[$];
  initial ready_out = 1'h0;
  // slow mode drops ready every other cycle so the skid word gets used
  always @(posedge clk_sys_in) begin
    if (nrst_in && valid_in && ready_out)
      q.push_back(data_in);
    ready_out <= !hold_in && (!slow_in || !ready_out);
  end
endmodule

// ===== sim/olm_top_bench.sv
/*
  self-checking bench of olm_top: descriptor tasks and scenario sequence.
  assumes olm_peer as far-side sink and one 125 MHz clock.
*/
module olm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import olm_pkg::*;
  localparam logic [47:0] SM = 48'h0A0B0C0D0E0F;
  logic clk_sys_in = 1'h0, nrst_in = 1'h0, frm_valid_in = 1'h0, frm_ready_out, frm_valid_out;
  logic frm_ready_in, hold = 1'h0, slow = 1'h0, err_s, yl = 1'h0, pr = 1'h0;
  olm_frame_type frm_in = '0, frm_out, g;
  olm_mel_type ml = OLM_MEL_SAME;
  logic mep_up_in = 1'h0, up_endpoint_loop_select_in = 1'h0;
  logic request_hw_handling_enable_in = 1'h1, request_copy_to_host_enable_in = 1'h0;
  logic reply_copy_to_host_enable_in = 1'h0, request_txn_id_update_enable_in = 1'h1;
  logic request_oam_count_enable_in = 1'h1, request_data_count_enable_in = 1'h1;
  logic yellow_frame_count_enable_in = 1'h0, path_link_in = 1'h1, protect_active_in = 1'h0;
  logic cfg_load_in = 1'h0, reply_txn_error_out;
  logic [7:0] generic_forward_mask_in = 8'h40, oam_in_data_count_ctrl_in = 8'h00;
  logic [7:0] class_counter_fold_mask_in = 8'h00;
  logic [3:0] protect_loopback_port_in = 4'h9;
  logic [9:0] protect_service_index_in = 10'h155, loopback_service_index_in = 10'h2A0;
  logic [9:0] loopback_service_index_out;
  logic [47:0] mep_mac_in = 48'hA1B2C3D4E5F6;
  logic [31:0] outgoing_request_txn_id_in = 32'h100, expected_reply_txn_id_in = 32'h200;
  logic [31:0] tid = 32'h0, cnt_value_out, reply_receive_counter_out;
  logic [31:0] outgoing_request_txn_id_out, expected_reply_txn_id_out;
  logic [31:0] received_sequence_store_out;
  logic [2:0] cnt_set_in = 3'h0, cnt_class_in = 3'h0;
  logic [4:0] lm_rx_seq_out;
  int num_errors = 0, num_checks = 0;

  olm_top dut (.clk_sys_in, .nrst_in, .frm_valid_in, .frm_in, .frm_ready_out, .frm_valid_out,
    .frm_out, .frm_ready_in, .mep_up_in, .up_endpoint_loop_select_in,
    .request_hw_handling_enable_in, .request_copy_to_host_enable_in,
    .reply_copy_to_host_enable_in, .request_txn_id_update_enable_in,
    .request_oam_count_enable_in, .request_data_count_enable_in, .generic_forward_mask_in,
    .oam_in_data_count_ctrl_in, .class_counter_fold_mask_in, .yellow_frame_count_enable_in,
    .path_link_in, .protect_active_in, .protect_loopback_port_in, .protect_service_index_in,
    .mep_mac_in, .cfg_load_in, .loopback_service_index_in, .outgoing_request_txn_id_in,
    .expected_reply_txn_id_in, .cnt_set_in, .cnt_class_in, .cnt_value_out,
    .reply_receive_counter_out, .reply_txn_error_out, .outgoing_request_txn_id_out,
    .expected_reply_txn_id_out, .loopback_service_index_out, .received_sequence_store_out,
    .lm_rx_seq_out);
  olm_peer peer (.clk_sys_in, .nrst_in, .valid_in(frm_valid_out), .data_in(frm_out),
    .hold_in(hold), .slow_in(slow), .ready_out(frm_ready_in));

  always #4 clk_sys_in = ~clk_sys_in;

  // ----
  // tasks
  // ----
  task chk(input logic [63:0] gv, input logic [63:0] ev);
    num_checks++;
    if (gv !== ev) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, gv, ev);
    end
  endtask
  task cnt(input logic [2:0] s, input logic [2:0] c, input logic [31:0] e);
    cnt_set_in = s;
    cnt_class_in = c;
    @(negedge clk_sys_in);
    chk(cnt_value_out, e);
  endtask
  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic olm_frame_type mk(input logic t, input olm_kind_type k,
    input logic [2:0] p);
    return '{tx_dir: t, kind: k, mel_rel: ml, pcp: p, yellow: yl, prot: pr, port: 4'h3,
      service_index: 10'h011, dmac: 48'h1, smac: SM, txn: tid, default: '0};
  endfunction
  // leaves valid up so two calls run back to back; the word is taken on return
  task send(input olm_frame_type f);
    int n;
    n = 0;
    frm_valid_in = 1'h1;
    frm_in = f;
    while (frm_ready_out !== 1'h1 && n < 50) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(n < 50, 1'h1);
    @(negedge clk_sys_in);
    err_s = reply_txn_error_out;
  endtask
  task pop;
    int n;
    n = 0;
    while (peer.q.size() == 0 && n < 20) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(n < 20, 1'h1);
    g = peer.q.pop_front();
  endtask
  task xfer(input olm_frame_type f);
    send(f);
    frm_valid_in = 1'h0;
    pop;
  endtask
  task load;
    cfg_load_in = 1'h1;
    @(negedge clk_sys_in);
    cfg_load_in = 1'h0;
  endtask

  // ----
  // scenarios
  // ----
  initial begin
    repeat (3) @(negedge clk_sys_in);
    nrst_in = 1'h1;
    chk(frm_ready_out, 1'h1);
    chk(reply_receive_counter_out, 32'h0);
    load;
    pr = 1'h1;
    for (int i = 0; i < 2; i++) begin
      protect_active_in = i[0];
      xfer(mk(1'h0, OLM_KIND_LBM, 3'h0));
      chk(g.kind, OLM_KIND_LBR);
      chk({g.tx_dir, g.dmac}, {1'h1, SM});
      chk(g.smac, mep_mac_in);
      chk(g.port, i ? 4'h9 : 4'h3);
      chk(g.service_index, i ? 10'h155 : 10'h2A0);
    end
    pr = 1'h0;
    xfer(mk(1'h1, OLM_KIND_LBM, 3'h0));
    chk(g.txn, 32'h100);
    chk(outgoing_request_txn_id_out, 32'h101);
    xfer(mk(1'h1, OLM_KIND_TST, 3'h0));
    chk(g.txn, 32'h101);
    request_oam_count_enable_in = 1'h0;
    xfer(mk(1'h1, OLM_KIND_TST, 3'h0));
    chk(outgoing_request_txn_id_out, 32'h102);
    request_oam_count_enable_in = 1'h1;
    tid = 32'h201;
    xfer(mk(1'h0, OLM_KIND_LBR, 3'h0));
    chk({err_s, reply_receive_counter_out}, 33'h1);
    chk(expected_reply_txn_id_out, 32'h201);
    tid = 32'h999;
    xfer(mk(1'h0, OLM_KIND_LBR, 3'h0));
    chk({err_s, reply_receive_counter_out}, 33'h100000002);
    mep_up_in = 1'h1;
    tid = 32'hFFFF0203;
    xfer(mk(1'h0, OLM_KIND_LBR, 3'h0));
    chk({err_s, expected_reply_txn_id_out}, 33'h203);
    mep_up_in = 1'h0;
    reply_copy_to_host_enable_in = 1'h1;
    tid = 32'h204;
    xfer(mk(1'h0, OLM_KIND_TST, 3'h0));
    chk({err_s, g.copy_host}, 2'h1);
    chk(reply_receive_counter_out, 32'h4);
    generic_forward_mask_in = 8'hBF;
    xfer(mk(1'h0, OLM_KIND_TST, 3'h0));
    chk(g.kind, OLM_KIND_OTHER);
    chk(reply_receive_counter_out, 32'h4);
    generic_forward_mask_in = 8'h40;
    reply_copy_to_host_enable_in = 1'h0;
    mep_up_in = 1'h1;
    request_copy_to_host_enable_in = 1'h1;
    xfer(mk(1'h0, OLM_KIND_LBM, 3'h0));
    chk({g.copy_host, g.kind}, {1'h1, OLM_KIND_LBM});
    up_endpoint_loop_select_in = 1'h1;
    xfer(mk(1'h0, OLM_KIND_LBM, 3'h0));
    chk(g.kind, OLM_KIND_LBR);
    chk(g.dmac, SM);
    chk(g.smac, mep_mac_in);
    xfer(mk(1'h1, OLM_KIND_LBM, 3'h0));
    chk(g.txn, 32'h102);
    up_endpoint_loop_select_in = 1'h0;
    request_copy_to_host_enable_in = 1'h0;
    mep_up_in = 1'h0;
    xfer(mk(1'h0, OLM_KIND_DATA, 3'h2));
    class_counter_fold_mask_in = 8'h20;
    xfer(mk(1'h0, OLM_KIND_DATA, 3'h5));
    yl = 1'h1;
    xfer(mk(1'h0, OLM_KIND_DATA, 3'h2));
    yellow_frame_count_enable_in = 1'h1;
    xfer(mk(1'h0, OLM_KIND_DATA, 3'h2));
    yl = 1'h0;
    ml = OLM_MEL_LOWER;
    xfer(mk(1'h0, OLM_KIND_LBM, 3'h0));
    chk(g.discard, 1'h1);
    ml = OLM_MEL_HIGHER;
    xfer(mk(1'h0, OLM_KIND_LBM, 3'h2));
    ml = OLM_MEL_SAME;
    oam_in_data_count_ctrl_in = 8'h08;
    xfer(mk(1'h0, OLM_KIND_TST, 3'h2));
    xfer(mk(1'h1, OLM_KIND_DATA, 3'h2));
    path_link_in = 1'h0;
    xfer(mk(1'h0, OLM_KIND_DATA, 3'h1));
    cnt(3'h0, 3'h2, 32'h4);
    cnt(3'h0, 3'h7, 32'h1);
    cnt(3'h0, 3'h0, 32'h0);
    cnt(3'h0, 3'h1, 32'h1);
    cnt(3'h1, 3'h2, 32'h1);
    cnt(3'h3, 3'h2, 32'h1);
    cnt(3'h2, 3'h1, 32'h0);
    cnt(3'h4, 3'h5, 32'h1);
    cnt(3'h5, 3'h2, 32'h1);
    path_link_in = 1'h1;
    xfer(mk(1'h0, OLM_KIND_LMR, 3'h2));
    chk({lm_rx_seq_out, received_sequence_store_out[25:21]}, 10'h021);
    chk(loopback_service_index_out[4:0], 5'h1);
    chk(g.extraction_rewrite_value[31:27], 5'h1);
    xfer(mk(1'h0, OLM_KIND_CCM_LM, 3'h2));
    chk(received_sequence_store_out[20:16], 5'h2);
    mep_up_in = 1'h1;
    xfer(mk(1'h0, OLM_KIND_LMM, 3'h2));
    chk(received_sequence_store_out[30:26], 5'h3);
    chk(g.fc_rx, 32'h4);
    mep_up_in = 1'h0;
    xfer(mk(1'h0, OLM_KIND_LMM, 3'h2));
    chk({g.kind, g.fc_rx, g.dmac[4:0]}, {OLM_KIND_LMR, 32'h4, 5'h0F});
    chk(lm_rx_seq_out, 5'h3);
    xfer(mk(1'h1, OLM_KIND_LMM, 3'h2));
    chk(g.fc_tx, 32'h1);
    xfer(mk(1'h1, OLM_KIND_LMR, 3'h2));
    chk(g.fc_tx, 32'h1);
    loopback_service_index_in = 10'h3C5;
    outgoing_request_txn_id_in = 32'hFFFFFFFF;
    load;
    chk(loopback_service_index_out, 10'h3C5);
    xfer(mk(1'h1, OLM_KIND_LBM, 3'h0));
    chk({g.txn, outgoing_request_txn_id_out}, 64'hFFFFFFFF00000000);
    request_hw_handling_enable_in = 1'h0;
    xfer(mk(1'h0, OLM_KIND_LBR, 3'h0));
    chk(reply_receive_counter_out, 32'h5);
    hold = 1'h1;
    send(mk(1'h0, OLM_KIND_DATA, 3'h1));
    send(mk(1'h0, OLM_KIND_DATA, 3'h6));
    chk(frm_ready_out, 1'h0);
    frm_valid_in = 1'h0;
    hold = 1'h0;
    slow = 1'h1;
    pop;
    chk(g.pcp, 3'h1);
    pop;
    chk(g.pcp, 3'h6);
    test_done;
  end

  // ----
  // watchdog
  // ----
  // the sequence needs well under 1000 cycles; 100 us is ample margin
  initial begin
    #100000;
    num_errors++;
    test_done;
  end
endmodule
